/* File: hdl/scs_map.vh */
/*
 * Constants for the switch control block: channel counts, shift widths,
 * positions inside the synchronised input vector and reset values.
 * Assumes it is included by bare name from the design files under hdl/.
 */
`ifndef SCS_MAP_VH
`define SCS_MAP_VH

// Channel counts
`define SCS_NCH        8
`define SCS_NHEAVY     6
`define SCS_NPAIR      3

// Serial shift path
`define SCS_SHW        16
`define SCS_SH_MSB     15
`define SCS_BYTE       8
`define SCS_CMD_W      6
`define SCS_CNT_W      5
`define SCS_CNT_8      5'h08
`define SCS_CNT_16     5'h10
`define SCS_CNT_ZERO   5'h00
`define SCS_CNT_ONE    5'h01

// Positions inside the synchronised input vector
`define SCS_SYNC_W     24
`define SCS_S_CS       0
`define SCS_S_SCLK     1
`define SCS_S_SI       2
`define SCS_S_MODE     3
`define SCS_S_OV       4
`define SCS_S_PAIR_LO  5
`define SCS_S_PAIR_HI  7
`define SCS_S_PAR_LO   8
`define SCS_S_PAR_HI   15
`define SCS_S_FLT_LO   16
`define SCS_S_FLT_HI   23

// Reset values
`define SCS_SYNC_RST   1'h0
`define SCS_CS_RST     1'h1
`define SCS_CMD_RST    6'h00
`define SCS_FLT_RST    8'h00
`define SCS_SH_RST     16'h0000
`define SCS_LOW_RST    8'h00
`define SCS_SW_N_RST   8'hff
`define SCS_OE_N_RST   1'h1

`endif

/* File: hdl/scs_sync.v */
/*
 * Bank of two-flop synchronisers, one per input bit.
 * Assumes every input bit is asynchronous to CLK_I and needs only
 * level transfer; edges are found downstream on the second flop.
 */
`include "scs_map.vh"
`timescale 1ns/1ps
`default_nettype none

module scs_sync (
  input  wire                     clk_i,     // Block clock
  input  wire                     reset_n_i, // Asynchronous reset, active low
  input  wire [`SCS_SYNC_W-1:0]   d_i,       // Raw asynchronous inputs
  output wire [`SCS_SYNC_W-1:0]   q_o        // Synchronised levels
);

  reg  [`SCS_SYNC_W-1:0] meta_r; // First stage, read only by second stage
  reg  [`SCS_SYNC_W-1:0] sync_r; // Second stage

  genvar b;
  generate
    for (b = 0; b < `SCS_SYNC_W; b = b + 1) begin : g_bit
      // Two flops per bit; chip select idles high out of reset
      always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          meta_r[b] <= (b == `SCS_S_CS) ? `SCS_CS_RST : `SCS_SYNC_RST;
          sync_r[b] <= (b == `SCS_S_CS) ? `SCS_CS_RST : `SCS_SYNC_RST;
        end else begin
          meta_r[b] <= d_i[b];
          sync_r[b] <= meta_r[b];
        end
      end
    end
  endgenerate

  assign q_o = sync_r;

endmodule

`default_nettype wire

/* File: hdl/scs_top.v */
/*
 * Control logic of an eight channel low-side switch: serial command port,
 * parallel inputs, paired overrides under mode select, fault status return
 * and over-voltage shutdown.
 * Assumes the host is the serial master and drives chip select, serial
 * clock and serial input; the serial clock is sampled by CLK_I, which must
 * run at least several times faster than it. Fault flags come from the
 * analog sense logic as levels.
 */
`include "scs_map.vh"
`timescale 1ns/1ps
`default_nettype none

module scs_top (
  input  wire                  CLK_I,                 // Block clock, 20 MHz
  input  wire                  RESET_N_I,             // Asynchronous reset, active low
  input  wire                  SPI_CS_N_I,            // Chip select from host, active low
  input  wire                  SPI_SCLK_I,            // Serial clock from host
  input  wire                  SPI_SI_I,              // Serial data from host
  output wire                  SPI_SO_O,              // Serial data to host
  output wire                  SPI_SO_OE_N_O,         // Serial output enable, low drives
  input  wire                  MODE_SEL_I,            // Mode select, high selects overrides
  input  wire                  BATTERY_SUPPLY_OV_I,   // Battery supply over-voltage flag
  input  wire                  PAIR_OVERRIDE_A_I,     // Override for channels 0 and 1
  input  wire                  PAIR_OVERRIDE_B_I,     // Override for channels 2 and 3
  input  wire                  PAIR_OVERRIDE_C_I,     // Override for channels 4 and 5
  input  wire [`SCS_NCH-1:0]   PARALLEL_CTL_I,        // Parallel control, one per channel
  input  wire [`SCS_NCH-1:0]   FAULT_SENSE_I,         // Fault flags from sense logic
  output wire [`SCS_NCH-1:0]   SWITCH_CH_N_O          // Switch outputs, low is on
);

  // Synchronised copies of every outside input except clock and reset
  wire [`SCS_SYNC_W-1:0] raw_in;   // Raw inputs gathered in one vector
  wire [`SCS_SYNC_W-1:0] sync_in;  // Same inputs after two flops

  assign raw_in = {FAULT_SENSE_I,
                   PARALLEL_CTL_I,
                   PAIR_OVERRIDE_C_I,
                   PAIR_OVERRIDE_B_I,
                   PAIR_OVERRIDE_A_I,
                   BATTERY_SUPPLY_OV_I,
                   MODE_SEL_I,
                   SPI_SI_I,
                   SPI_SCLK_I,
                   SPI_CS_N_I};

  // Two-flop synchroniser bank for all input pins but clock and reset
  scs_sync u_sync (
    .clk_i     (CLK_I),
    .reset_n_i (RESET_N_I),
    .d_i       (raw_in),
    .q_o       (sync_in)
  );

  // Named views of the synchronised vector
  wire                   cs_n_s;   // Chip select, active low
  wire                   sclk_s;   // Serial clock level
  wire                   si_s;     // Serial input level
  wire                   mode_s;   // Mode select level
  wire                   ov_s;     // Over-voltage level
  wire [`SCS_NPAIR-1:0]  pair_s;   // Pair overrides, c b a
  wire [`SCS_NCH-1:0]    par_s;    // Parallel controls
  wire [`SCS_NCH-1:0]    flt_s;    // Fault sense flags

  assign cs_n_s = sync_in[`SCS_S_CS];
  assign sclk_s = sync_in[`SCS_S_SCLK];
  assign si_s   = sync_in[`SCS_S_SI];
  assign mode_s = sync_in[`SCS_S_MODE];
  assign ov_s   = sync_in[`SCS_S_OV];
  assign pair_s = sync_in[`SCS_S_PAIR_HI:`SCS_S_PAIR_LO];
  assign par_s  = sync_in[`SCS_S_PAR_HI:`SCS_S_PAR_LO];
  assign flt_s  = sync_in[`SCS_S_FLT_HI:`SCS_S_FLT_LO];

  // Delayed copies for edge detection, taken from the second flop
  reg                    cs_n_d_r; // Chip select one cycle ago
  reg                    sclk_d_r; // Serial clock one cycle ago

  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cs_n_d_r <= `SCS_CS_RST;
      sclk_d_r <= `SCS_SYNC_RST;
    end else begin
      cs_n_d_r <= cs_n_s;
      sclk_d_r <= sclk_s;
    end
  end

  // Edge strobes, one cycle each
  wire cs_fall;   // Transfer starts
  wire cs_rise;   // Transfer ends
  wire sclk_rise; // Sample edge inside a transfer
  wire sclk_fall; // Output edge inside a transfer

  assign cs_fall   = cs_n_d_r & ~cs_n_s;
  assign cs_rise   = ~cs_n_d_r & cs_n_s;
  assign sclk_rise = ~cs_n_s & ~sclk_d_r & sclk_s;
  assign sclk_fall = ~cs_n_s & sclk_d_r & ~sclk_s;

  // Serial state
  reg  [`SCS_NCH-1:0]    fault_r;  // Fault status register
  reg  [`SCS_SHW-1:0]    shift_r;  // Status out, command in
  reg  [`SCS_CNT_W-1:0]  bits_r;   // Rising edges seen this transfer
  reg  [`SCS_CMD_W-1:0]  cmd_r;    // Latched serial command
  reg                    so_r;     // Serial output bit
  reg                    so_oe_n_r;// Serial output enable, low drives

  // Fault register follows sense flags only while deselected
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      fault_r <= `SCS_FLT_RST;
    end else if (cs_n_s) begin
      fault_r <= flt_s;
    end
  end

  // Shift register: load status at start, shift in on rising edges
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      shift_r <= `SCS_SH_RST;
    end else if (cs_fall) begin
      // Status byte leads, channel 7 in the top bit
      shift_r <= {fault_r, `SCS_LOW_RST};
    end else if (sclk_rise) begin
      // Received bits enter at the bottom; the first byte fills the low half after eight
      shift_r <= {shift_r[`SCS_SH_MSB-1:0], si_s};
    end
  end

  // Count rising edges so that a short transfer is discarded
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      bits_r <= `SCS_CNT_ZERO;
    end else if (cs_fall) begin
      bits_r <= `SCS_CNT_ZERO;
    end else if (sclk_rise && (bits_r != `SCS_CNT_16)) begin
      bits_r <= bits_r + `SCS_CNT_ONE;
    end
  end

  // Command latch on chip select rise; the last byte in is the one kept
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cmd_r <= `SCS_CMD_RST;
    end else if (cs_rise && ((bits_r == `SCS_CNT_8) || (bits_r == `SCS_CNT_16))) begin
      // Low six bits of the final byte map to channels 5 down to 0
      cmd_r <= shift_r[`SCS_CMD_W-1:0];
    end
  end

  // Serial output: first bit at select, next bits on falling edges
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      so_r      <= `SCS_SYNC_RST;
      so_oe_n_r <= `SCS_OE_N_RST;
    end else begin
      // Drive only while selected and mode select is low
      so_oe_n_r <= cs_n_s | mode_s;
      if (cs_fall) begin
        so_r <= fault_r[`SCS_NCH-1];
      end else if (sclk_fall) begin
        // Status leaves from the top; after eight rises the first byte is echoed
        if (bits_r < `SCS_CNT_8) begin
          so_r <= shift_r[`SCS_SH_MSB];
        end else begin
          so_r <= shift_r[`SCS_BYTE-1];
        end
      end
    end
  end

  // Gate decision per channel, gate high means channel on
  reg  [`SCS_NCH-1:0]    gate_nxt; // Next gate states
  reg  [`SCS_NCH-1:0]    sw_n_r;   // Registered switch outputs

  genvar ch;
  generate
    for (ch = 0; ch < `SCS_NCH; ch = ch + 1) begin : g_ch
      if (ch < `SCS_NHEAVY) begin : g_heavy
        // Heavy channel: override pair under mode, else command OR pin
        always @* begin
          if (ov_s) begin
            gate_nxt[ch] = 1'b0;
          end else if (mode_s) begin
            gate_nxt[ch] = pair_s[ch / 2];
          end else begin
            gate_nxt[ch] = cmd_r[ch] | par_s[ch];
          end
        end
      end else begin : g_light
        // Light channel: parallel pin only, off under mode select
        always @* begin
          if (ov_s || mode_s) begin
            gate_nxt[ch] = 1'b0;
          end else begin
            gate_nxt[ch] = par_s[ch];
          end
        end
      end
    end
  endgenerate

  // Switch outputs are the inverted gates
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sw_n_r <= `SCS_SW_N_RST;
    end else begin
      sw_n_r <= ~gate_nxt;
    end
  end

  assign SPI_SO_O      = so_r;
  assign SPI_SO_OE_N_O = so_oe_n_r;
  assign SWITCH_CH_N_O = sw_n_r;

endmodule

`default_nettype wire

/* File: verification/scs_monitor.sv */
/* Port checker for scs_top.
   Assumes it is bound into scs_top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module scs_monitor (
  input wire logic       CLK_I,
  input wire logic       RESET_N_I,
  input wire logic       SPI_CS_N_I,
  input wire logic       SPI_SCLK_I,
  input wire logic       SPI_SO_O,
  input wire logic       SPI_SO_OE_N_O,
  input wire logic       MODE_SEL_I,
  input wire logic       BATTERY_SUPPLY_OV_I,
  input wire logic       PAIR_OVERRIDE_A_I,
  input wire logic       PAIR_OVERRIDE_B_I,
  input wire logic       PAIR_OVERRIDE_C_I,
  input wire logic [7:0] PARALLEL_CTL_I,
  input wire logic [7:0] FAULT_SENSE_I,
  input wire logic [7:0] SWITCH_CH_N_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  wire       f7 = FAULT_SENSE_I[7];  // Status bit sent first
  wire [5:0] pr = {{2{PAIR_OVERRIDE_C_I}}, {2{PAIR_OVERRIDE_B_I}}, {2{PAIR_OVERRIDE_A_I}}};
  property p_ov_off; BATTERY_SUPPLY_OV_I [*6] |-> SWITCH_CH_N_O == 8'hff; endproperty
  a_ov_off: assert property (p_ov_off) else $error("channel on during over-voltage");
  property p_oe_idle; (SPI_CS_N_I || MODE_SEL_I) [*6] |-> SPI_SO_OE_N_O; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("serial output driven while idle");
  property p_oe_on; (!SPI_CS_N_I && !MODE_SEL_I) [*6] |-> !SPI_SO_OE_N_O; endproperty
  a_oe_on: assert property (p_oe_on) else $error("serial output not driven");
  property p_mode_map;
    (MODE_SEL_I && !BATTERY_SUPPLY_OV_I && $stable(pr)) [*6] |-> SWITCH_CH_N_O == {2'b11, ~pr};
  endproperty
  a_mode_map: assert property (p_mode_map) else $error("override map wrong");
  property p_par_on;
    (!MODE_SEL_I && !BATTERY_SUPPLY_OV_I && $stable(PARALLEL_CTL_I)) [*6] |-> (SWITCH_CH_N_O & PARALLEL_CTL_I) == 8'h00;
  endproperty
  a_par_on: assert property (p_par_on) else $error("parallel request not honoured");
  property p_cs_hold;
    (!SPI_CS_N_I && !MODE_SEL_I && !BATTERY_SUPPLY_OV_I && $stable(PARALLEL_CTL_I)) [*8] |-> $stable(SWITCH_CH_N_O);
  endproperty
  a_cs_hold: assert property (p_cs_hold) else $error("outputs moved inside a frame");
  property p_so_hold; (!SPI_CS_N_I && SPI_SCLK_I) [*4] |-> $stable(SPI_SO_O); endproperty
  a_so_hold: assert property (p_so_hold) else $error("serial output moved while clock high");
  property p_status;
    (SPI_CS_N_I && !MODE_SEL_I && $stable(FAULT_SENSE_I)) [*6] ##1 (!SPI_CS_N_I && !MODE_SEL_I)
      |-> ##6 SPI_SO_O == $past(f7, 7);
  endproperty
  a_status: assert property (p_status) else $error("first status bit wrong");
endmodule
bind scs_top scs_monitor u_scs_monitor (.CLK_I, .RESET_N_I, .SPI_CS_N_I, .SPI_SCLK_I, .SPI_SO_O, .SPI_SO_OE_N_O,
  .MODE_SEL_I, .BATTERY_SUPPLY_OV_I, .PAIR_OVERRIDE_A_I, .PAIR_OVERRIDE_B_I, .PAIR_OVERRIDE_C_I,
  .PARALLEL_CTL_I, .FAULT_SENSE_I, .SWITCH_CH_N_O);
`default_nettype wire

/* File: verification/scs_host.sv */
/* Host serial master model for the switch block.
   Assumes the bench calls xfer; link clock period 400 ns, idle low. */
`timescale 1ns/1ps
`default_nettype none
module scs_host (
  output logic      cs_n_o,    // Chip select, active low
  output logic      sclk_o,    // Link clock, still between frames
  output logic      si_o,      // Data to the block
  input  wire logic so_i,      // Data from the block
  input  wire logic so_oe_n_i  // Low while the block drives
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o   = 1'b0;
  end
  // One frame of n bits, MSB first; q collects the returned bits
  task automatic xfer(input int n, input logic [15:0] d, output logic [15:0] q);
    int i;
    q = 16'h0000;
    #13 cs_n_o = 1'b0;
    for (i = n - 1; i >= 0; i--) begin
      si_o = d[i];
      #200 sclk_o = 1'b1;
      // A released output reads high through its pull-up
      #200 q = {q[14:0], so_oe_n_i ? 1'b1 : so_i};
      sclk_o = 1'b0;
    end
    #100 cs_n_o = 1'b1;
    si_o = ~si_o;  // Released line shows no stale bit
    #1000;
  endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
/* Self-checking bench for scs_top.
   Assumes scs_monitor is bound in and scs_host drives the serial port. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, reset_n, mode, ov, pa, pb, pc, cs_n, sclk, si, so, so_oe_n, kind;
  logic [7:0]  par, flt, sw_n;
  logic [15:0] rx, d;
  logic [15:0] expq[$];
  logic [5:0]  cmd;
  int          n_errors, samples_checked, i;
  event        seen;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  scs_top u_scs_top (.CLK_I(clk), .RESET_N_I(reset_n), .SPI_CS_N_I(cs_n), .SPI_SCLK_I(sclk), .SPI_SI_I(si),
    .SPI_SO_O(so), .SPI_SO_OE_N_O(so_oe_n), .MODE_SEL_I(mode), .BATTERY_SUPPLY_OV_I(ov), .PAIR_OVERRIDE_A_I(pa),
    .PAIR_OVERRIDE_B_I(pb), .PAIR_OVERRIDE_C_I(pc), .PARALLEL_CTL_I(par), .FAULT_SENSE_I(flt), .SWITCH_CH_N_O(sw_n));
  scs_host u_scs_host (.cs_n_o(cs_n), .sclk_o(sclk), .si_o(si), .so_i(so), .so_oe_n_i(so_oe_n));
  // Compare one value against its note
  task chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // Watcher takes the oldest note when a result is announced
  always @(seen) chk(kind ? rx : {8'h00, sw_n}, expq.pop_front());
  // Expected switch outputs from the current inputs
  function automatic logic [15:0] exp_sw(input logic [5:0] c);
    logic [7:0] g;
    g = {par[7:6], par[5:0] | c};
    if (mode) g = {2'b00, {2{pc}}, {2{pb}}, {2{pa}}};
    if (ov) g = 8'h00;
    return {8'h00, ~g};
  endfunction
  task post(input logic k, input logic [15:0] e);
    repeat (8) @(negedge clk);
    kind = k;
    expq.push_back(e);
    -> seen;
    #1;
  endtask
  task frame(input int n, input logic [15:0] e_rx);
    repeat (8) @(negedge clk);
    u_scs_host.xfer(n, d, rx);
    post(1'b1, e_rx);
    post(1'b0, exp_sw(cmd));
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #2000000 n_errors++;
    end_sim();
  end
  initial begin
    {reset_n, mode, ov, pa, pb, pc, kind} = 7'h00;
    {par, flt, cmd, rx, d} = 54'h0;
    n_errors = 0;
    samples_checked = 0;
    void'($urandom(67));
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    post(1'b0, exp_sw(cmd));
    $display("test reset done");
    for (i = 0; i < 12; i++) begin
      par = $urandom & $urandom;
      flt = $urandom;
      d = $urandom;
      {pa, pb, pc} = $urandom;
      cmd = d[5:0];
      frame(i % 2 ? 16 : 8, i % 2 ? {flt, d[15:8]} : {8'h00, flt});
    end
    $display("test frames done");
    d = 16'h003f;
    frame(7, {9'h000, flt[7:1]});
    $display("test short frame done");
    mode = 1'b1;
    for (i = 0; i < 8; i++) begin
      {pa, pb, pc} = i[2:0];
      par = $urandom;
      post(1'b0, exp_sw(cmd));
    end
    d = 16'h0015;
    cmd = 6'h15;
    frame(8, 16'h00ff);
    mode = 1'b0;
    post(1'b0, exp_sw(cmd));
    $display("test mode done");
    for (i = 0; i < 2; i++) begin
      ov = 1'b1;
      mode = i[0];
      post(1'b0, exp_sw(cmd));
    end
    {ov, mode} = 2'b00;
    post(1'b0, exp_sw(cmd));
    $display("test over-voltage done");
    par = 8'h00;
    post(1'b0, exp_sw(cmd));
    reset_n = 1'b0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    cmd = 6'h00;
    post(1'b0, exp_sw(cmd));
    $display("test second reset done");
    end_sim();
  end
endmodule
`default_nettype wire
